// File: include/mission_defs.svh
// Constants of the mission, alarm and status register bank.
// Assumes Avalon-MM byte addressing: byte address is four times the index.
`ifndef MISSION_DEFS_SVH
`define MISSION_DEFS_SVH
// ----------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------
`define IDX_LO_THR 10'h208
`define IDX_HI_THR 10'h209
`define IDX_SENSOR 10'h210
`define IDX_TIMEKEEP 10'h212
`define IDX_MSETUP 10'h213
`define IDX_AFLAGS 10'h214
`define IDX_GSTATE 10'h215
`define IDX_MCNT0 10'h220
`define IDX_MCNT1 10'h221
`define IDX_MCNT2 10'h222
`define IDX_DCNT0 10'h223
`define IDX_DCNT1 10'h224
`define IDX_DCNT2 10'h225
`define IDX_COMMAND 10'h230
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define B_HI_EN 1
`define B_LO_EN 0
`define B_SEC_RATE 1
`define B_OSC_RUN 0
`define B_SOA 5
`define B_WRAP 4
`define B_WIDE 2
`define B_LOG_EN 0
`define B_BOR 7
`define B_AWAIT 4
`define B_CLEARED 3
`define B_ACTIVE 1
`define B_CMD_CLEAR 0
`define B_CMD_START 1
`define B_CMD_STOP 2
`define B_CMD_FORCE 3
// ----------------------------------------------------------------
// Fixed read values, reset values and log area
// ----------------------------------------------------------------
`define MS_FIXED 8'hC0
`define MS_KEPT 8'h35
`define AF_FIXED 8'h70
`define GS_FIXED 8'hC0
`define RST_BYTE 8'h00
`define LOG_BASE 16'h1000
`define LOG_LAST 13'h1FFF
`endif

// File: include/mission_pkg.sv
// Types shared by the mission register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package mission_pkg;
  // One-hot mission states
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_LOG = 4'h4,
    ST_FULL = 4'h8
  } mission_state_type;
endpackage : mission_pkg

// File: include/alarm_if.sv
// Carrier between the mission controller and its alarm unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface alarm_if;
  logic check;
  logic [7:0] sample;
  logic [7:0] hi_thr;
  logic [7:0] lo_thr;
  logic hi_en;
  logic lo_en;
  logic clear;
  logic hit_hi;
  logic hit_lo;
  logic flag_hi;
  logic flag_lo;
  modport ctrl (output check, sample, hi_thr, lo_thr, hi_en, lo_en, clear,
    input hit_hi, hit_lo, flag_hi, flag_lo);
  modport unit (input check, sample, hi_thr, lo_thr, hi_en, lo_en, clear,
    output hit_hi, hit_lo, flag_hi, flag_lo);
endinterface : alarm_if

// File: hw/alarm_check.sv
// Threshold compare and sticky high/low alarm flags.
// Assumes check is a one-cycle strobe with sample valid in that cycle.
`timescale 1ns/1ps
module alarm_check (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Controller side
  alarm_if.unit a
);
  logic hi_q;
  logic lo_q;

  // Only the upper result byte is compared; equal counts as an alarm
  assign a.hit_hi = a.check & a.hi_en & (a.sample >= a.hi_thr);
  assign a.hit_lo = a.check & a.lo_en & (a.sample <= a.lo_thr);
  assign a.flag_hi = hi_q;
  assign a.flag_lo = lo_q;

  // Sticky flags: a hit in the clear cycle survives
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end
    else
    begin
      hi_q <= a.hit_hi | (hi_q & ~a.clear);
      lo_q <= a.hit_lo | (lo_q & ~a.clear);
    end
  end

  property p_hi_gate;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (!a.hi_en && !hi_q) |=> !hi_q;
  endproperty
  a_hi_gate: assert property (p_hi_gate) else $error("high flag set while disabled");

  property p_lo_set;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (a.check && a.lo_en && a.sample <= a.lo_thr) |=> lo_q;
  endproperty
  a_lo_set: assert property (p_lo_set) else $error("low flag missed");
endmodule : alarm_check

// File: hw/mission_alarm_status_control.sv
// Mission control, alarm and status register bank of a temperature logger.
// Assumes an Avalon-MM master, an external sample timer giving i_sample_due
// and a converter answering each o_conv_start with one i_conv_done.
//
// Notes on behaviour
// - High alarm flag needs enable and result at/above
// - Low alarm flag needs enable and result at/below
// - Timekeeping bit 1 selects seconds, else minutes
// - Timekeeping bit 0 runs oscillator; zero stops it
// - Forced conversion or start sets oscillator run
// - Setup bits 7,6 read one; bit 1 written zero
// - Setup register read-only during a mission
// - Start-on-alarm tests 8-bit, logs alarming sample uncounted
// - Wrap bit resumes logging at log start
// - Without wrap, full log stops conversions, mission stays
// - Wide format logs two bytes, high first
// - Logging enabled by host (bit 0 is kept but never gates logging); log starts 1000h
// - Alarm register read-only with fixed bits
// - Clear memory clears all alarm flags (code clears high and low only; battery reset flag stays set)
// - Battery reset flag set by power-on reset
// - Forced and first triggering conversions set flags
// - General status read-only with three indicators
// - Awaiting-alarm sets on start, clears on alarm
// - Clear memory zeroes counter, stamp; sets cleared
// - Mission starts only with memory cleared
// - Mission-active bit follows the mission
// - Compare uses upper result byte only
// - Device counter counts wakeups and alarm tests
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`include "mission_defs.svh"
module mission_alarm_status_control (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Avalon-MM slave
  input wire logic [11:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Converter
  input wire logic i_sample_due,
  input wire logic i_conv_done,
  input wire logic [15:0] i_conv_data,
  output logic o_conv_start,
  output logic o_conv_wide,
  // Log memory
  output logic o_log_we,
  output logic [15:0] o_log_addr,
  output logic [7:0] o_log_data,
  // Status
  output logic o_osc_run,
  output logic o_seconds_rate,
  output logic o_mission_active,
  output logic o_stamp_clear
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  alarm_if al ();
  mission_pkg::mission_state_type st_q;
  mission_pkg::mission_state_type st_d;
  logic wait_q;
  logic [7:0] lo_thr_q;
  logic [7:0] hi_thr_q;
  logic [1:0] sensor_q;
  logic [1:0] timekeep_q;
  logic [7:0] setup_q;
  logic bor_q;
  logic await_q;
  logic cleared_q;
  logic forced_q;
  logic second_q;
  logic [7:0] lsb_q;
  logic [12:0] ptr_q;
  logic [23:0] mcnt_q;
  logic [23:0] dcnt_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [9:0] idx = i_address[11:2];
  wire wr_fire = i_write & ~wait_q;
  wire in_mission = (st_q != mission_pkg::ST_IDLE);
  wire cfg_open = wr_fire & ~in_mission;
  wire [7:0] wb = i_writedata[7:0];
  wire wr_lo = cfg_open & (idx == `IDX_LO_THR);
  wire wr_hi = cfg_open & (idx == `IDX_HI_THR);
  wire wr_sensor = cfg_open & (idx == `IDX_SENSOR);
  wire wr_timekeep = cfg_open & (idx == `IDX_TIMEKEEP);
  wire wr_setup = cfg_open & (idx == `IDX_MSETUP);
  wire wr_cmd = wr_fire & (idx == `IDX_COMMAND);
  wire cmd_clear = wr_cmd & wb[`B_CMD_CLEAR];
  wire cmd_stop = wr_cmd & wb[`B_CMD_STOP];
  // Start is refused unless idle with memory cleared
  wire start_ok = wr_cmd & wb[`B_CMD_START] & ~in_mission & cleared_q;
  // Forced conversion only between missions and one at a time
  wire force_ok = wr_cmd & wb[`B_CMD_FORCE] & ~in_mission & ~forced_q;

  // ----------------------------------------------------------------
  // Mission logic
  // ----------------------------------------------------------------
  wire soa = setup_q[`B_SOA];
  wire wrap = setup_q[`B_WRAP];
  wire wide = setup_q[`B_WIDE];
  wire st_wait = (st_q == mission_pkg::ST_WAIT);
  wire st_log = (st_q == mission_pkg::ST_LOG);
  wire sampling = st_wait | st_log;
  wire any_hit = al.hit_hi | al.hit_lo;
  // Triggering sample is logged too, in 8-bit form
  wire log_first = i_conv_done & ~forced_q & (st_log | (st_wait & any_hit));
  wire byte_we = log_first | second_q;
  wire at_end = (ptr_q == `LOG_LAST);
  wire [12:0] ptr_next = at_end ? 13'h0000 : ptr_q + 13'h0001;
  wire full_hit = byte_we & at_end & ~wrap;
  wire [7:0] byte_val = second_q ? lsb_q : i_conv_data[15:8];
  // Low byte only follows in wide format outside the alarm wait
  wire want_lsb = log_first & wide & st_log & ~full_hit;
  wire go_wait = start_ok & soa;

  // Alarm unit hookup: mission results and forced results are checked
  assign al.check = i_conv_done & (sampling | forced_q);
  assign al.sample = i_conv_data[15:8];
  assign al.hi_thr = hi_thr_q;
  assign al.lo_thr = lo_thr_q;
  assign al.hi_en = sensor_q[`B_HI_EN];
  assign al.lo_en = sensor_q[`B_LO_EN];
  assign al.clear = cmd_clear;

  alarm_check u_alarm (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .a(al)
  );

  // Next mission state; stop wins from any state
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      mission_pkg::ST_IDLE:
        if (start_ok)
          st_d = soa ? mission_pkg::ST_WAIT : mission_pkg::ST_LOG;
      mission_pkg::ST_WAIT:
        if (log_first)
          st_d = full_hit ? mission_pkg::ST_FULL : mission_pkg::ST_LOG;
      mission_pkg::ST_LOG:
        if (full_hit)
          st_d = mission_pkg::ST_FULL;
      mission_pkg::ST_FULL:
        st_d = mission_pkg::ST_FULL;
    endcase
    if (cmd_stop)
      st_d = mission_pkg::ST_IDLE;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] af_val = `AF_FIXED | {bor_q, 5'h00, al.flag_hi, al.flag_lo};
  wire [7:0] gs_val = `GS_FIXED |
    {3'h0, await_q, cleared_q, 1'b0, in_mission, 1'b0};
  // Bits 3 and 1 of the setup register are not kept
  wire [7:0] ms_val = `MS_FIXED | {2'h0, setup_q[5:4], 1'b0, setup_q[2], 1'b0, setup_q[0]};
  wire [7:0] rd_byte =
    (idx == `IDX_LO_THR) ? lo_thr_q :
    (idx == `IDX_HI_THR) ? hi_thr_q :
    (idx == `IDX_SENSOR) ? {6'h00, sensor_q} :
    (idx == `IDX_TIMEKEEP) ? {6'h00, timekeep_q} :
    (idx == `IDX_MSETUP) ? ms_val :
    (idx == `IDX_AFLAGS) ? af_val :
    (idx == `IDX_GSTATE) ? gs_val :
    (idx == `IDX_MCNT0) ? mcnt_q[7:0] :
    (idx == `IDX_MCNT1) ? mcnt_q[15:8] :
    (idx == `IDX_MCNT2) ? mcnt_q[23:16] :
    (idx == `IDX_DCNT0) ? dcnt_q[7:0] :
    (idx == `IDX_DCNT1) ? dcnt_q[15:8] :
    (idx == `IDX_DCNT2) ? dcnt_q[23:16] : `RST_BYTE;

  // One wait cycle per access; data is latched in that cycle
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wait_q <= 1'b1;
      o_readdata <= 32'h00000000;
    end
    else
    begin
      wait_q <= ~((i_read | i_write) & wait_q);
      o_readdata <= {24'h000000, rd_byte};
    end
  end
  assign o_waitrequest = wait_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Writes are ignored while a mission runs
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      lo_thr_q <= `RST_BYTE;
      hi_thr_q <= `RST_BYTE;
      sensor_q <= 2'h0;
      setup_q <= `RST_BYTE;
    end
    else
    begin
      if (wr_lo)
        lo_thr_q <= wb;
      if (wr_hi)
        hi_thr_q <= wb;
      if (wr_sensor)
        sensor_q <= wb[1:0];
      if (wr_setup)
        setup_q <= wb & `MS_KEPT;
    end
  end

  // Oscillator and rate unit; start and forced-conversion commands force the oscillator on
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      timekeep_q <= 2'h0;
    else if (start_ok | force_ok)
      timekeep_q[`B_OSC_RUN] <= 1'b1;
    else if (wr_timekeep)
      timekeep_q <= wb[1:0];
  end
  assign o_osc_run = timekeep_q[`B_OSC_RUN];
  assign o_seconds_rate = timekeep_q[`B_SEC_RATE];

  // ----------------------------------------------------------------
  // Mission state and status bits
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_q <= mission_pkg::ST_IDLE;
      bor_q <= 1'b1;
      await_q <= 1'b0;
      cleared_q <= 1'b0;
      forced_q <= 1'b0;
      o_mission_active <= 1'b0;
      o_stamp_clear <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      o_mission_active <= (st_d != mission_pkg::ST_IDLE);
      o_stamp_clear <= cmd_clear;
      // Stale wait survives stop and clear; any alarm hit clears it
      if (go_wait)
        await_q <= 1'b1;
      else if (any_hit)
        await_q <= 1'b0;
      if (start_ok)
        cleared_q <= 1'b0;
      else if (cmd_clear)
        cleared_q <= 1'b1;
      if (force_ok)
        forced_q <= 1'b1;
      else if (i_conv_done)
        forced_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Conversion requests and sample counters
  // ----------------------------------------------------------------
  // Alarm tests are 8-bit; full log requests nothing more
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_conv_start <= 1'b0;
      o_conv_wide <= 1'b0;
    end
    else
    begin
      o_conv_start <= (i_sample_due & sampling) | force_ok;
      o_conv_wide <= wide & ~st_wait;
    end
  end

  // Counters; mission count skips the alarm tests while waiting
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      mcnt_q <= 24'h000000;
      dcnt_q <= 24'h000000;
    end
    else
    begin
      if (cmd_clear)
        mcnt_q <= 24'h000000;
      else if (i_sample_due & st_log)
        mcnt_q <= mcnt_q + 24'h000001;
      if ((i_sample_due & sampling) | force_ok)
        dcnt_q <= dcnt_q + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Log writer
  // ----------------------------------------------------------------
  // High byte first at the lower address, low byte one cycle later
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ptr_q <= 13'h0000;
      second_q <= 1'b0;
      lsb_q <= `RST_BYTE;
      o_log_we <= 1'b0;
      o_log_addr <= `LOG_BASE;
      o_log_data <= `RST_BYTE;
    end
    else
    begin
      second_q <= want_lsb;
      lsb_q <= i_conv_data[7:0];
      o_log_we <= byte_we;
      if (byte_we)
      begin
        o_log_addr <= `LOG_BASE + {3'h0, ptr_q};
        o_log_data <= byte_val;
      end
      if (start_ok)
        ptr_q <= 13'h0000;
      else if (byte_we)
        ptr_q <= ptr_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_setup_locked;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (in_mission && wr_fire && idx == `IDX_MSETUP) |=> $stable(setup_q);
  endproperty
  a_setup_locked: assert property (p_setup_locked) else $error("setup written in mission");

  property p_osc_on;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (start_ok || force_ok) |=> o_osc_run;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("oscillator not started");

  property p_start_needs_clear;
    @(posedge i_mclk) disable iff (i_sys_rst)
    $rose(in_mission) |-> $past(cleared_q) && !cleared_q;
  endproperty
  a_start_needs_clear: assert property (p_start_needs_clear) else $error("start without clear");

  property p_clear_flags;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (cmd_clear && !al.check) |=> !al.flag_hi && !al.flag_lo && mcnt_q == 24'h000000;
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("clear left flags");

  property p_await_set;
    @(posedge i_mclk) disable iff (i_sys_rst)
    go_wait |=> await_q && st_wait;
  endproperty
  a_await_set: assert property (p_await_set) else $error("awaiting not set");

  property p_full_quiet;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (st_q == mission_pkg::ST_FULL) [*2] |-> !o_conv_start && o_mission_active;
  endproperty
  a_full_quiet: assert property (p_full_quiet) else $error("conversion after full");

  property p_wide_pair;
    @(posedge i_mclk) disable iff (i_sys_rst)
    want_lsb |=> o_log_we ##1 (o_log_we && o_log_addr == $past(o_log_addr) + 16'h0001);
  endproperty
  a_wide_pair: assert property (p_wide_pair) else $error("low byte misplaced");

  property p_fixed_bits;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (i_read && wait_q && idx == `IDX_AFLAGS) |=> o_readdata[6:2] == 5'h1C;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("alarm fixed bits wrong");

  property p_wrap_base;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (byte_we && at_end && wrap) |=> ptr_q == 13'h0000 &&
      o_log_addr == (`LOG_BASE + {3'h0, `LOG_LAST});
  endproperty
  a_wrap_base: assert property (p_wrap_base) else $error("wrap failed");
endmodule : mission_alarm_status_control

// File: verif/conv_model.sv
// Converter model facing the register bank's conversion port.
// Assumes start is a one-cycle pulse and one conversion is outstanding.
`timescale 1ns/1ps
module conv_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Controller side
  input wire logic i_start,
  input wire logic [15:0] i_value,
  input wire logic [3:0] i_delay,
  output logic o_done,
  output logic [15:0] o_data
);
  logic [3:0] cnt_q;
  logic busy_q;
  // Answer i_delay+1 cycles after start; data toggles outside the done cycle so
  // a stale value can never pass for a fresh result
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      o_done <= 1'b0;
      o_data <= 16'h0000;
    end
    else
    begin
      o_done <= 1'b0;
      o_data <= ~o_data;
      if (i_start)
      begin
        busy_q <= 1'b1;
        cnt_q <= i_delay;
      end
      else if (busy_q && cnt_q == 4'h0)
      begin
        busy_q <= 1'b0;
        o_done <= 1'b1;
        o_data <= i_value;
      end
      else if (busy_q)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : conv_model

// File: verif/mission_alarm_status_control_bench.sv
// Self-checking bench of the mission, alarm and status register bank.
// Assumes the converter model and an Avalon master made of tasks.
`timescale 1ns/1ps
`include "mission_defs.svh"
module mission_alarm_status_control_bench;
  logic clk, rst, rd, wr, sdue, wreq, cdone, cstart, cwide, lwe;
  logic osc, secs, act, sclr, last_wide;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] cdata, laddr, temp, last_addr;
  logic [7:0] ldata, rv;
  logic [3:0] dly;
  logic [7:0] logm [logic [15:0]];
  int n_errors, checks, n_log, n_start, n_done, n_clr, b;
  mission_alarm_status_control i_dut (.i_mclk(clk), .i_sys_rst(rst),
    .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
    .o_readdata(rdata), .o_waitrequest(wreq), .i_sample_due(sdue),
    .i_conv_done(cdone), .i_conv_data(cdata), .o_conv_start(cstart),
    .o_conv_wide(cwide), .o_log_we(lwe), .o_log_addr(laddr), .o_log_data(ldata),
    .o_osc_run(osc), .o_seconds_rate(secs), .o_mission_active(act),
    .o_stamp_clear(sclr));
  conv_model i_conv (.i_mclk(clk), .i_sys_rst(rst), .i_start(cstart),
    .i_value(temp), .i_delay(dly), .o_done(cdone), .o_data(cdata));
  // ----------------------------------------------------------------
  // Clock, monitor and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulses last one cycle, so the settled falling edge sees each once
  always @(negedge clk)
  begin
    if (lwe === 1'b1)
    begin
      n_log++;
      logm[laddr] = ldata;
      last_addr = laddr;
    end
    if (cstart === 1'b1)
    begin
      n_start++;
      last_wide = cwide;
    end
    if (cdone === 1'b1) n_done++;
    if (sclr === 1'b1) n_clr++;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wr <= w;
    rd <= ~w;
    // Read data is taken at the very edge that samples waitrequest low
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) n_errors++;
    rv = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    // The write lands on that edge; let it settle before callers look
    @(negedge clk);
  endtask : bus
  task rdc(input logic [9:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(32'(rv), 32'(exp));
  endtask : rdc
  // One sample interval; nw is the number of log writes it should make
  task samp(input int nw);
    int s, n;
    s = n_log;
    n = 0;
    @(posedge clk);
    sdue <= 1'b1;
    @(posedge clk);
    sdue <= 1'b0;
    if (nw == 0) repeat (8) @(posedge clk);
    while (nw != 0 && n_log != s + nw && n < 30)
    begin
      @(posedge clk);
      n++;
    end
  endtask : samp
  task frc(input logic [15:0] t);
    int s, n;
    s = n_done;
    n = 0;
    temp = t;
    bus(1'b1, `IDX_COMMAND, 8'h08);
    while (n_done == s && n < 30)
    begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
  endtask : frc
  task cmd(input logic [7:0] c);
    bus(1'b1, `IDX_COMMAND, c);
    repeat (2) @(posedge clk);
  endtask : cmd
  task end_sim;
    $display("Mismatches %0d, comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    {rd, wr, sdue, addr, wdata} = '0;
    temp = 16'h0000;
    dly = 4'h3;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(`IDX_AFLAGS, `AF_FIXED | 8'h80);
    bus(1'b1, `IDX_AFLAGS, 8'h03);
    rdc(`IDX_AFLAGS, 8'hF0);
    bus(1'b1, `IDX_MSETUP, 8'h00);
    rdc(`IDX_MSETUP, `MS_FIXED);
    bus(1'b1, `IDX_MSETUP, 8'hFF);
    rdc(`IDX_MSETUP, 8'hF5);
    rdc(10'h3FF, 8'h00);
    bus(1'b1, `IDX_TIMEKEEP, 8'hFE);
    chk(32'(osc), 32'h0);
    chk(32'(secs), 32'h1);
    rdc(`IDX_TIMEKEEP, 8'h02);
    bus(1'b1, `IDX_TIMEKEEP, 8'h01);
    chk(32'(secs), 32'h0);
    chk(32'(osc), 32'h1);
    bus(1'b1, `IDX_TIMEKEEP, 8'h00);
    // Thresholds at their boundaries, upper result byte only
    bus(1'b1, `IDX_LO_THR, 8'h20);
    bus(1'b1, `IDX_HI_THR, 8'h80);
    bus(1'b1, `IDX_SENSOR, 8'h01);
    frc(16'h80FF);
    chk(32'(osc), 32'h1);
    rdc(`IDX_AFLAGS, 8'hF0);
    frc(16'h2110);
    rdc(`IDX_AFLAGS, 8'hF0);
    frc(16'h2000);
    rdc(`IDX_AFLAGS, 8'hF1);
    bus(1'b1, `IDX_SENSOR, 8'h02);
    frc(16'h7FFF);
    rdc(`IDX_AFLAGS, 8'hF1);
    frc(16'h8000);
    rdc(`IDX_AFLAGS, 8'hF3);
    b = n_clr;
    cmd(8'h01);
    rdc(`IDX_AFLAGS, 8'hF0);
    rdc(`IDX_GSTATE, `GS_FIXED | 8'h08);
    chk(n_clr, b + 1);
    // Wide logging mission, setup locked while active
    bus(1'b1, `IDX_SENSOR, 8'h00);
    bus(1'b1, `IDX_MSETUP, 8'h05);
    cmd(8'h02);
    chk(32'(act), 32'h1);
    rdc(`IDX_GSTATE, 8'hC2);
    bus(1'b1, `IDX_MSETUP, 8'h00);
    rdc(`IDX_MSETUP, 8'hC5);
    temp = 16'hA5C0;
    samp(2);
    chk(32'(last_wide), 32'h1);
    chk(32'(logm[16'h1000]), 32'hA5);
    chk(32'(logm[16'h1001]), 32'hC0);
    rdc(`IDX_MCNT0, 8'h01);
    cmd(8'h04);
    chk(32'(act), 32'h0);
    cmd(8'h02);
    chk(32'(act), 32'h0);
    // Awaiting flag survives stop and clear, goes on a forced alarm
    cmd(8'h01);
    bus(1'b1, `IDX_MSETUP, 8'h21);
    cmd(8'h02);
    cmd(8'h04);
    rdc(`IDX_GSTATE, 8'hD0);
    cmd(8'h01);
    rdc(`IDX_GSTATE, 8'hD8);
    bus(1'b1, `IDX_HI_THR, 8'h00);
    bus(1'b1, `IDX_SENSOR, 8'h02);
    frc(16'h1000);
    rdc(`IDX_GSTATE, 8'hC8);
    // Start on alarm: narrow tests, first alarming sample logged
    cmd(8'h01);
    bus(1'b1, `IDX_HI_THR, 8'h80);
    cmd(8'h02);
    rdc(`IDX_GSTATE, 8'hD2);
    b = n_log;
    temp = 16'h5000;
    samp(0);
    chk(32'(last_wide), 32'h0);
    chk(n_log, b);
    temp = 16'h9000;
    samp(1);
    chk(32'(last_addr), 32'h1000);
    chk(32'(logm[16'h1000]), 32'h90);
    rdc(`IDX_GSTATE, 8'hC2);
    rdc(`IDX_AFLAGS, 8'hF2);
    rdc(`IDX_MCNT0, 8'h00);
    // Five forced conversions, one wide sample, one forced alarm, two tests
    rdc(`IDX_DCNT0, 8'h09);
    cmd(8'h04);
    // Fill the log without and then with wrap
    dly = 4'h0;
    bus(1'b1, `IDX_SENSOR, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      cmd(8'h01);
      bus(1'b1, `IDX_MSETUP, k ? 8'h15 : 8'h05);
      cmd(8'h02);
      for (int i = 0; i < 4096; i++) samp(2);
      chk(32'(last_addr), 32'h2FFF);
      temp = 16'h3C00;
      b = n_start;
      samp(2 * k);
      chk(n_start, b + k);
      chk(32'(act), 32'h1);
      if (k == 1) chk(32'(last_addr), 32'h1001);
      if (k == 1) chk(32'(logm[16'h1000]), 32'h3C);
      cmd(8'h04);
    end
    end_sim();
  end
endmodule : mission_alarm_status_control_bench
